// ---- logic/gxl_pkg.sv ----
package gxl_pkg;
    localparam int NUM_PINS = 4;

    // Register offsets
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h01;
    localparam logic [7:0] ADDR_IRQ_PIN_GATE = 8'h05;
    localparam logic [7:0] ADDR_EDGE_SELECT_LOWER = 8'h07;
    localparam logic [7:0] ADDR_IRQ_CAUSE_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_EDGE_EVENT_FLAGS = 8'h09;
    localparam logic [7:0] ADDR_LOGIC_MODE_SELECT = 8'h10;
    localparam logic [7:0] ADDR_TWO_INPUT_TABLE = 8'h11;
    localparam logic [7:0] ADDR_UNUSED_TABLE_A = 8'h12;
    localparam logic [7:0] ADDR_THREE_INPUT_TABLE = 8'h13;
    localparam logic [7:0] ADDR_UNUSED_TABLE_B = 8'h14;
    localparam logic [7:0] ADDR_UNUSED_TABLE_C = 8'h15;
    localparam logic [7:0] ADDR_ADVANCED_SETTINGS = 8'hab;

    // Reset values
    localparam logic [7:0] RST_PIN_LEVEL = 8'hff;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'hff;
    localparam logic [7:0] RST_IRQ_PIN_GATE = 8'hff;
    localparam logic [7:0] RST_EDGE_SELECT_LOWER = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_LOGIC_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_TRUTH_TABLE = 8'h00;
    localparam logic [7:0] RST_ADVANCED_SETTINGS = 8'h00;

    // Field positions
    localparam int LOGIC_MODE_MSB = 1;
    localparam int LOGIC_MODE_LSB = 0;
    localparam int BOOST_BIT = 1;
    localparam int TWO_INPUT_PIN = 2;
    localparam int THREE_INPUT_PIN = 3;

    // Logic mode field encodings
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_DECODE2 = 2'h1;
    localparam logic [1:0] MODE_DECODE3 = 2'h2;

    // Edge select encodings
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Serial slave framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } gxl_req_type;
endpackage : gxl_pkg

// ---- logic/gxl_serial_slave.sv ----
`timescale 1ns/1ps
module gxl_serial_slave import gxl_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary slave address
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Sync reset, active high
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe_o, // Serial data drive enable
    output gxl_req_type req_o, // Register access request
    input wire logic [7:0] rdata_i // Read data at req_o.addr
);
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK
    } gxl_state_type;

    gxl_state_type state_r;
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic read_mode_r;
    logic have_ptr_r;
    logic nack_r;
    logic [7:0] ptr_r;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Pins pass two flops; edge logic reads only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_prev_r <= scl_sync_r[1];
            sda_prev_r <= sda_sync_r[1];
        end
    end

    assign scl_rise = scl_sync_r[1] & ~scl_prev_r;
    assign scl_fall = ~scl_sync_r[1] & scl_prev_r;
    assign start_seen = scl_sync_r[1] & scl_prev_r & sda_prev_r & ~sda_sync_r[1];
    assign stop_seen = scl_sync_r[1] & scl_prev_r & ~sda_prev_r & sda_sync_r[1];
    assign sda_o = 1'b0;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= S_IDLE;
            shift_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            read_mode_r <= 1'b0;
            have_ptr_r <= 1'b0;
            nack_r <= 1'b0;
            ptr_r <= 8'h00;
            sda_oe_o <= 1'b0;
            req_o <= '0;
        end else begin
            req_o.wr <= 1'b0;
            req_o.rd <= 1'b0;
            if (start_seen) begin
                state_r <= S_ADDR;
                bit_cnt_r <= 4'h0;
                have_ptr_r <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_seen) begin
                state_r <= S_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    S_ADDR, S_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_sync_r[1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
                            bit_cnt_r <= 4'h0;
                            if (state_r == S_ADDR) begin
                                if (shift_r[7:1] == DEV_ADDR) begin
                                    read_mode_r <= shift_r[0];
                                    sda_oe_o <= 1'b1;
                                    state_r <= S_ADDR_ACK;
                                end else begin
                                    state_r <= S_IDLE;
                                end
                            end else begin
                                // First byte after address is the pointer [RULE_16]
                                if (!have_ptr_r) begin
                                    ptr_r <= shift_r;
                                    // Read mux is addressed by req_o.addr
                                    req_o.addr <= shift_r;
                                    have_ptr_r <= 1'b1;
                                end else begin
                                    req_o.wr <= 1'b1;
                                    req_o.addr <= ptr_r;
                                    req_o.data <= shift_r;
                                    ptr_r <= ptr_r + 8'h01;
                                end
                                sda_oe_o <= 1'b1;
                                state_r <= S_RX_ACK;
                            end
                        end
                    end
                    S_ADDR_ACK, S_RX_ACK: begin
                        if (scl_fall) begin
                            if (state_r == S_ADDR_ACK && read_mode_r) begin
                                // Load first read byte while SCL is low [RULE_16]
                                shift_r <= {rdata_i[6:0], 1'b0};
                                sda_oe_o <= ~rdata_i[7];
                                req_o.rd <= 1'b1;
                                req_o.addr <= ptr_r + 8'h01;
                                ptr_r <= ptr_r + 8'h01;
                                bit_cnt_r <= 4'h1;
                                state_r <= S_TX;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state_r <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == BITS_PER_BYTE) begin
                                sda_oe_o <= 1'b0;
                                state_r <= S_TX_ACK;
                            end else begin
                                sda_oe_o <= ~shift_r[7];
                                shift_r <= {shift_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    S_TX_ACK: begin
                        if (scl_rise) begin
                            nack_r <= sda_sync_r[1];
                        end else if (scl_fall) begin
                            if (nack_r) begin
                                state_r <= S_IDLE;
                            end else begin
                                shift_r <= {rdata_i[6:0], 1'b0};
                                sda_oe_o <= ~rdata_i[7];
                                req_o.rd <= 1'b1;
                                req_o.addr <= ptr_r + 8'h01;
                                ptr_r <= ptr_r + 8'h01;
                                bit_cnt_r <= 4'h1;
                                state_r <= S_TX;
                            end
                        end
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : gxl_serial_slave

// ---- logic/gxl_expander.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Selected edge on a pin sets its event flag; otherwise flag stays 0
// RULE_02 - Writing 1 to an event flag clears it and its interrupt cause flag
// RULE_03 - Changing a pin's edge select clears that pin's event flag
// RULE_04 - Logic mode 00 plain, 01 two-input decode, 10 three-input decode, 11 unused
// RULE_05 - Two-input decode drives pin 2 from first table indexed by pins 1..0
// RULE_06 - Three-input decode drives pin 3 from third table indexed by pins 2..0
// RULE_07 - Advanced settings bit 1 switches boost on, 0 switches it off
// RULE_08 - Host writes zero to reserved bits
// RULE_09 - Level register write sets levels driven on output pins
// RULE_10 - Level register read returns actual pin levels regardless of direction
// RULE_11 - Direction bit 0 output, 1 input; resets to all ones
// RULE_12 - Edge select 00 none, 01 rising, 10 falling, 11 both
// RULE_13 - Event sets interrupt cause only when pin gate bit is 0
// RULE_14 - Interrupt output low while any cause flag set, high when all clear
// RULE_15 - Decoded pin becomes an output overriding the level register
// RULE_16 - Registers reached by byte reads and writes over the serial slave port
module gxl_expander import gxl_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary slave address
) (
    input wire logic clk_i, // System clock, 20 MHz
    input wire logic reset_i, // Sync reset, active high
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe_o, // Serial data drive enable
    input wire logic [NUM_PINS-1:0] pin_i, // Pin levels
    output logic [NUM_PINS-1:0] pin_o, // Pin drive values
    output logic [NUM_PINS-1:0] pin_oe_o, // Pin drive enables
    output logic irq_out_n_o, // Interrupt, active low
    output logic boost_en_o // Boost mode enable
);
    gxl_req_type req;
    logic [7:0] rdata;
    logic [7:0] pin_level_r;
    logic [7:0] pin_direction_r;
    logic [7:0] irq_pin_gate_r;
    logic [7:0] edge_select_lower_r;
    logic [7:0] irq_cause_flags_r;
    logic [7:0] edge_event_flags_r;
    logic [7:0] logic_mode_select_r;
    logic [7:0] two_input_truth_table_r;
    logic [7:0] three_input_truth_table_r;
    logic [7:0] advanced_settings_r;
    logic [NUM_PINS-1:0] pin_meta_r;
    logic [NUM_PINS-1:0] pin_sync_r;
    logic [NUM_PINS-1:0] pin_prev_r;
    logic [NUM_PINS-1:0] edge_hit;
    logic [NUM_PINS-1:0] sense_changed;
    logic [NUM_PINS-1:0] flag_clear;
    logic [NUM_PINS-1:0] drive_val_nxt;
    logic [NUM_PINS-1:0] drive_oe_nxt;
    logic [1:0] logic_mode_field;
    logic wr_sel;

    gxl_serial_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_slave (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .req_o(req),
        .rdata_i(rdata)
    );

    // Pins pass two flops; edge detector reads the second stage only
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_meta_r <= '1;
            pin_sync_r <= '1;
            pin_prev_r <= '1;
        end else begin
            pin_meta_r <= pin_i;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign logic_mode_field = logic_mode_select_r[LOGIC_MODE_MSB:LOGIC_MODE_LSB];

    // Per-pin edge qualification and flag clear terms
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic [1:0] sel;
            logic rise;
            logic fall;
            assign sel = edge_select_lower_r[2*g+1:2*g];
            assign rise = pin_sync_r[g] & ~pin_prev_r[g];
            assign fall = ~pin_sync_r[g] & pin_prev_r[g];
            always_comb begin
                case (sel) // [RULE_12]
                    EDGE_RISE: edge_hit[g] = rise;
                    EDGE_FALL: edge_hit[g] = fall;
                    EDGE_BOTH: edge_hit[g] = rise | fall;
                    default: edge_hit[g] = 1'b0;
                endcase
            end
            // Sense change seen on the write itself [RULE_03]
            assign sense_changed[g] = wr_sel && req.data[2*g+1:2*g] != sel;
            assign flag_clear[g] = sense_changed[g] |
                (req.wr && req.addr == ADDR_EDGE_EVENT_FLAGS && req.data[g]) |
                (req.wr && req.addr == ADDR_IRQ_CAUSE_FLAGS && req.data[g]);
        end
    endgenerate

    assign wr_sel = req.wr && req.addr == ADDR_EDGE_SELECT_LOWER;

    // Plain read/write registers [RULE_16]
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_level_r <= RST_PIN_LEVEL;
            pin_direction_r <= RST_PIN_DIRECTION; // [RULE_11]
            irq_pin_gate_r <= RST_IRQ_PIN_GATE;
            edge_select_lower_r <= RST_EDGE_SELECT_LOWER;
            logic_mode_select_r <= RST_LOGIC_MODE_SELECT;
            two_input_truth_table_r <= RST_TRUTH_TABLE;
            three_input_truth_table_r <= RST_TRUTH_TABLE;
            advanced_settings_r <= RST_ADVANCED_SETTINGS;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_PIN_LEVEL: pin_level_r <= req.data; // [RULE_09]
                ADDR_PIN_DIRECTION: pin_direction_r <= req.data; // [RULE_11]
                ADDR_IRQ_PIN_GATE: irq_pin_gate_r <= req.data;
                ADDR_EDGE_SELECT_LOWER: edge_select_lower_r <= req.data;
                ADDR_LOGIC_MODE_SELECT: logic_mode_select_r <= req.data; // [RULE_04]
                ADDR_TWO_INPUT_TABLE: two_input_truth_table_r <= req.data;
                ADDR_THREE_INPUT_TABLE: three_input_truth_table_r <= req.data;
                ADDR_ADVANCED_SETTINGS: advanced_settings_r <= req.data; // [RULE_07]
                default: begin
                end
            endcase
        end
    end

    // Event flags: a new edge wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            edge_event_flags_r <= RST_FLAGS;
        end else begin
            edge_event_flags_r[NUM_PINS-1:0] <=
                (edge_event_flags_r[NUM_PINS-1:0] & ~flag_clear) | edge_hit; // [RULE_01] [RULE_02] [RULE_03]
        end
    end

    // Cause flags gated per pin; also cleared with the event flag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_cause_flags_r <= RST_FLAGS;
        end else begin
            irq_cause_flags_r[NUM_PINS-1:0] <= (irq_cause_flags_r[NUM_PINS-1:0] & ~flag_clear) |
                (edge_hit & ~irq_pin_gate_r[NUM_PINS-1:0]); // [RULE_13] [RULE_02]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_out_n_o <= 1'b1;
        end else begin
            irq_out_n_o <= ~(|irq_cause_flags_r[NUM_PINS-1:0]); // [RULE_14]
        end
    end

    assign boost_en_o = advanced_settings_r[BOOST_BIT]; // [RULE_07]

    // Pin drive; decode uses synchronised levels, so output lags inputs by 3 clocks
    always_comb begin
        drive_val_nxt = pin_level_r[NUM_PINS-1:0]; // [RULE_09]
        drive_oe_nxt = ~pin_direction_r[NUM_PINS-1:0]; // [RULE_11]
        case (logic_mode_field) // [RULE_04]
            MODE_DECODE2: begin
                drive_val_nxt[TWO_INPUT_PIN] = two_input_truth_table_r[pin_sync_r[1:0]]; // [RULE_05]
                drive_oe_nxt[TWO_INPUT_PIN] = 1'b1; // [RULE_15]
            end
            MODE_DECODE3: begin
                drive_val_nxt[THREE_INPUT_PIN] = three_input_truth_table_r[pin_sync_r[2:0]]; // [RULE_06]
                drive_oe_nxt[THREE_INPUT_PIN] = 1'b1; // [RULE_15]
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_o <= RST_PIN_LEVEL[NUM_PINS-1:0];
            pin_oe_o <= '0;
        end else begin
            pin_o <= drive_val_nxt;
            pin_oe_o <= drive_oe_nxt;
        end
    end

    // Read mux; reserved and unmapped offsets read zero
    always_comb begin
        case (req.addr)
            ADDR_PIN_LEVEL: rdata = {pin_level_r[7:NUM_PINS], pin_sync_r}; // [RULE_10]
            ADDR_PIN_DIRECTION: rdata = pin_direction_r;
            ADDR_IRQ_PIN_GATE: rdata = irq_pin_gate_r;
            ADDR_EDGE_SELECT_LOWER: rdata = edge_select_lower_r;
            ADDR_IRQ_CAUSE_FLAGS: rdata = irq_cause_flags_r;
            ADDR_EDGE_EVENT_FLAGS: rdata = edge_event_flags_r;
            ADDR_LOGIC_MODE_SELECT: rdata = logic_mode_select_r;
            ADDR_TWO_INPUT_TABLE: rdata = two_input_truth_table_r;
            ADDR_THREE_INPUT_TABLE: rdata = three_input_truth_table_r;
            ADDR_ADVANCED_SETTINGS: rdata = advanced_settings_r;
            default: rdata = 8'h00;
        endcase
    end
endmodule : gxl_expander

// ---- tb/gxl_expander_monitor.sv ----
`timescale 1ns/1ps
module gxl_expander_monitor import gxl_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Sync reset
    input wire logic scl_i, // Serial clock
    input wire logic sda_i, // Serial data
    input wire logic sda_o, // Data drive value
    input wire logic sda_oe_o, // Data drive enable
    input wire logic [NUM_PINS-1:0] pin_i, // Pin levels
    input wire logic [NUM_PINS-1:0] pin_o, // Pin drive values
    input wire logic [NUM_PINS-1:0] pin_oe_o, // Pin drive enables
    input wire logic irq_out_n_o, // Interrupt, active low
    input wire logic boost_en_o // Boost enable
);
    logic [NUM_PINS-1:0] pin_d_r;
    logic scl_d_r;
    logic [7:0] pin_age_r;
    logic [7:0] fall_age_r;

    always_ff @(posedge clk_i) begin
        pin_d_r <= pin_i;
        scl_d_r <= scl_i;
    end

    // Cycles since a pin moved, saturating
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_age_r <= 8'hff;
        end else if (pin_i != pin_d_r) begin
            pin_age_r <= 8'h00;
        end else if (pin_age_r != 8'hff) begin
            pin_age_r <= pin_age_r + 8'h01;
        end
    end

    // Cycles since the last SCL fall; every register write lands shortly after one
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fall_age_r <= 8'hff;
        end else if (scl_d_r && !scl_i) begin
            fall_age_r <= 8'h00;
        end else if (fall_age_r != 8'hff) begin
            fall_age_r <= fall_age_r + 8'h01;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sda_release_a: assert property (sda_oe_o |-> sda_o == 1'b0 && fall_age_r <= 8'h14)
        else $error("serial data held with clock idle");
    reset_idle_a: assert property ($fell(reset_i) |-> pin_oe_o == 4'h0 && irq_out_n_o && !boost_en_o)
        else $error("outputs not idle after reset");
    irq_set_a: assert property ($fell(irq_out_n_o) |-> pin_age_r <= 8'h08)
        else $error("interrupt without pin edge");
    irq_clear_a: assert property ($rose(irq_out_n_o) |-> fall_age_r <= 8'h0a)
        else $error("interrupt released without host write");
    dir_write_a: assert property ($changed(pin_oe_o) |-> fall_age_r <= 8'h0a)
        else $error("pin enable moved without host write");
    level_write_a: assert property ($changed(pin_o) |-> fall_age_r <= 8'h0a || pin_age_r <= 8'h05)
        else $error("pin drive moved without cause");
    boost_write_a: assert property ($changed(boost_en_o) |-> fall_age_r <= 8'h0a)
        else $error("boost moved without host write");
    ack_drive_a: assert property ($changed(sda_oe_o) |-> !scl_i && fall_age_r <= 8'h06)
        else $error("serial data moved outside SCL low");
endmodule : gxl_expander_monitor

bind gxl_expander gxl_expander_monitor u_gxl_expander_monitor (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .irq_out_n_o(irq_out_n_o), .boost_en_o(boost_en_o));

// ---- tb/gxl_host_model.sv ----
`timescale 1ns/1ps
module gxl_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary slave address
) (
    input wire logic clk_i, // System clock
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Serial clock
    output logic sda_low_o // High pulls data low
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_clk

    task automatic start_cond();
        wait_clk(4);
        sda_low_o = 1'b0;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low_o = 1'b1;
        wait_clk(4);
        scl_o = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(4);
        sda_low_o = 1'b1;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low_o = 1'b0;
        wait_clk(4);
    endtask : stop_cond

    // Data moves mid-low so no false START or STOP is seen
    task automatic bit_xfer(input logic b, output logic seen);
        wait_clk(4);
        sda_low_o = !b;
        wait_clk(4);
        scl_o = 1'b1;
        wait_clk(8);
        seen = sda_i;
        scl_o = 1'b0;
    endtask : bit_xfer

    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, ack_n);
    endtask : send_byte

    task automatic reg_write(input logic [6:0] dev, input logic [7:0] addr, input logic [7:0] data,
                             output logic ack_n);
        logic a0, a1, a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(addr, a1);
        send_byte(data, a2);
        stop_cond();
        ack_n = a0 | a1 | a2;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ack_n);
        logic a0, a1, a2, s;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(addr, a1);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            data[i] = s;
        end
        bit_xfer(1'b1, s);
        stop_cond();
        ack_n = a0 | a1 | a2;
    endtask : reg_read
endmodule : gxl_host_model

// ---- tb/gxl_expander_logic_regs_test.sv ----
`timescale 1ns/1ps
module gxl_expander_logic_regs_test import gxl_pkg::*;;
    localparam logic [6:0] DEV = 7'h20; // Arbitrary bus address
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] mask;
        logic [7:0] rexp;
    } gxl_row_type;
    localparam gxl_row_type ROWS [15] = '{
        '{1'b0, 8'h00, 8'h00, 8'h0f, 8'h0a},
        '{1'b0, 8'h01, 8'h00, 8'hff, 8'hff},
        '{1'b0, 8'h09, 8'h00, 8'hff, 8'h00},
        '{1'b0, 8'h10, 8'h00, 8'hff, 8'h00},
        '{1'b0, 8'h11, 8'h00, 8'hff, 8'h00},
        '{1'b0, 8'hab, 8'h00, 8'hff, 8'h00},
        '{1'b1, 8'h13, 8'ha5, 8'hff, 8'ha5},
        '{1'b1, 8'h11, 8'h09, 8'hff, 8'h09},
        '{1'b1, 8'h12, 8'h5a, 8'hff, 8'h00},
        '{1'b1, 8'h14, 8'h5a, 8'hff, 8'h00},
        '{1'b1, 8'h15, 8'h5a, 8'hff, 8'h00},
        '{1'b1, 8'h40, 8'h77, 8'hff, 8'h00},
        '{1'b1, 8'hab, 8'h02, 8'hff, 8'h02},
        '{1'b1, 8'h01, 8'h03, 8'h0f, 8'h03},
        '{1'b1, 8'h00, 8'hf6, 8'h0f, 8'h06}};
    localparam logic [3:0] MODE_OE [4] = '{4'h0, 4'h4, 4'h8, 4'h0};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] ext_pin = 4'ha;
    logic scl, sda_low, sda_o, sda_oe_o, irq_n, boost, sda_w, ack_n;
    logic [3:0] pin_o, pin_oe_o, pin_w;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;

    // Open-drain data line with pull-up; pins resolve the driving side
    assign sda_w = !(sda_low || (sda_oe_o && !sda_o));
    assign pin_w = (pin_oe_o & pin_o) | (~pin_oe_o & ext_pin);

    gxl_expander #(.DEV_ADDR(DEV)) u_gxl_expander (.clk_i(clk_i), .reset_i(reset_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pin_i(pin_w), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .irq_out_n_o(irq_n), .boost_en_o(boost));
    gxl_host_model #(.DEV_ADDR(DEV)) u_gxl_host_model (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
        .sda_low_o(sda_low));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic an;
        u_gxl_host_model.reg_write(DEV, a, d, an);
        check(an, 1'b0);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] v;
        logic an;
        u_gxl_host_model.reg_read(a, v, an);
        check(an, 1'b0);
        check(v & mask, exp);
    endtask : rd_chk

    task automatic report_and_stop();
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("[FAIL] %0t ns: run did not complete", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        check(pin_oe_o, 4'h0);
        check(irq_n, 1'b1);
        check(boost, 1'b0);
        for (int i = 0; i < 15; i++) begin
            if (ROWS[i].we) wr(ROWS[i].addr, ROWS[i].wdata);
            rd_chk(ROWS[i].addr, ROWS[i].mask, ROWS[i].rexp);
        end
        check(boost, 1'b1);
        check(pin_oe_o, 4'hc);
        check(pin_o[3:2], 2'h1);
        wr(8'hab, 8'h00);
        check(boost, 1'b0);
        // Foreign address must be ignored
        u_gxl_host_model.reg_write(7'h21, 8'h13, 8'h00, ack_n);
        check(ack_n, 1'b1);
        rd_chk(8'h13, 8'hff, 8'ha5);
        wr(8'h01, 8'h0f);
        for (int m = 0; m < 4; m++) begin
            wr(8'h10, 8'(m));
            for (int idx = 0; idx < 8; idx++) begin
                ext_pin = {1'b0, 3'(idx)};
                repeat (8) @(negedge clk_i);
                check(pin_oe_o, MODE_OE[m]);
                if (m == 1) check(pin_o[2], 8'h09 >> idx[1:0] & 8'h01);
                if (m == 2) check(pin_o[3], 8'ha5 >> idx[2:0] & 8'h01);
            end
        end
        wr(8'h10, 8'h00);
        rd_chk(8'h09, 8'hff, 8'h00);
        ext_pin = 4'h2;
        repeat (8) @(negedge clk_i);
        wr(8'h07, 8'h79);
        wr(8'h05, 8'hf8);
        ext_pin = 4'hd;
        repeat (10) @(negedge clk_i);
        check(irq_n, 1'b0);
        rd_chk(8'h09, 8'hff, 8'h0f);
        rd_chk(8'h08, 8'hff, 8'h07);
        wr(8'h09, 8'h01);
        rd_chk(8'h08, 8'hff, 8'h06);
        check(irq_n, 1'b0);
        wr(8'h09, 8'h0e);
        check(irq_n, 1'b1);
        ext_pin = 4'h2;
        repeat (10) @(negedge clk_i);
        rd_chk(8'h09, 8'hff, 8'h04);
        wr(8'h07, 8'h69);
        rd_chk(8'h09, 8'hff, 8'h00);
        wr(8'h08, 8'h04);
        check(irq_n, 1'b1);
        report_and_stop();
    end
endmodule : gxl_expander_logic_regs_test
